// *** core/io_port_defs.vh ***
// Register offsets, field positions, reset values and pin counts for the configurable I/O port block.
`ifndef IO_PORT_DEFS_VH
`define IO_PORT_DEFS_VH
// Register index within a port's register group (address bits 3:0).
`define REG_INPUT_LEVELS 4'h0
`define REG_OUTPUT_LATCH 4'h1
`define REG_OUTPUT_CELL 4'h2
`define REG_CELL_MASK 4'h3
`define REG_INPUT_CELL 4'h4
`define REG_ENABLE_READBACK 4'h5
`define REG_MODE_CONTROL 4'h6
`define REG_DIRECTION 4'h7
`define REG_DRIVE_SELECT 4'h8
// Port select (address bits 5:4).
`define PORT_A 2'h0
`define PORT_B 2'h1
`define PORT_C 2'h2
`define PORT_D 2'h3
// Reset value of every configuration register.
`define CFG_RESET 8'h00
// Peripheral buffer enable bit in the memory map configuration register.
`define PERIPH_MODE_BIT 7
// Port D pin mask: three pins.
`define PORT_D_MASK 8'h07
// Drive select split on ports A and B: upper nibble open drain, lower slew.
`define AB_OPEN_DRAIN_MASK 8'hf0
`define AB_SLEW_MASK 8'h0f
`endif

// *** core/io_port_block.v ***
// Configurable four-port I/O block with host registers, address out and peripheral buffer modes.
//
// Behaviour
// - Logic I/O pin tri-stated by term and direction 0
// - Address out needs enable term or direction and mode
// - Non-multiplexed bus puts A7-A0 on port B
// - Address inputs latch in input cell on strobe
// - Port A data-bus mode disables its general I/O
// - Config bit 7 makes port A peripheral buffer
// - Peripheral buffer tri-stated without either select
// - Mode, direction and drive registers reset to 00h
// - Register bit n affects only pin n
// - Ports A, B mode 0 host I/O, 1 address
// - Direction 1 output, 0 input, default input
// - Output when direction or enable term is 1
// - Port D uses only three direction bits
// - Drive bit 1 selects open drain, default push-pull
// - Open drain and slew bit split per port
// - Slew bit 1 selects fast edge, default slow
// - Pin input read returns synchronised pin levels
// - Output latch holds, drives and reads back data
// - Output cell read returns cells, write loads unmasked
// - Mask bit 1 blocks output cell loading
// - Enable readback shows each A, B, C pin's effective enable
// - Ports C, D host I/O without mode register
`timescale 1ns/1ps
`default_nettype none
`include "io_port_defs.vh"

// ==========================================================
// Register map and usage notes
// ==========================================================
// Address bits 5:4 pick the port and bits 3:0 the register in its group:
// 0 pin levels, 1 output latch, 2 output cells, 3 cell load mask,
// 4 input cells, 5 enable readback, 6 mode, 7 direction, 8 drive select.
// Writes to a register that a port lacks are ignored, and it reads as zero.
// Pin levels reach the host two clocks late, through the synchroniser.
// Input cells load three clocks after the strobe falls, for the same reason.
// Open drain pins only pull low; a high output value releases the pin.
// Host software must keep direction bits clear on pins that feed the
// logic array, or the block and the outside source fight over the wire.

module io_port_block
(
   input wire clock,
   input wire arst_n,
   // Host register access.
   input wire [5:0] host_addr,
   input wire host_wr,
   input wire host_rd,
   input wire [7:0] host_wdata,
   output reg [7:0] host_rdata,
   // Host data bus for data-port and peripheral modes.
   input wire [7:0] host_data_out,
   output wire [7:0] host_data_in,
   input wire host_data_drive,
   input wire host_addr_nonmux,
   input wire [7:0] host_low_addr,
   input wire [7:0] host_high_addr,
   input wire address_latch_strobe,
   // Static configuration from programming.
   input wire data_port_mode,
   input wire [7:0] memory_map_config_register,
   input wire periph_select_first,
   input wire periph_select_second,
   // Logic array terms, one set per port: A in 7:0, B 15:8, C 23:16, D 26:24.
   input wire [26:0] logic_oe_term,
   input wire [26:0] logic_out_en,
   input wire [26:0] logic_out_data,
   input wire [23:0] addr_input_sel,
   output wire [23:0] input_cell_out,
   output wire [26:0] pin_sync_levels,
   // Pins.
   input wire [26:0] pin_in,
   output wire [26:0] pin_out,
   output wire [26:0] pin_oe_n,
   output wire [26:0] pin_fast_slew
);

   // ==========================================================
   // Storage
   // ==========================================================
   reg [7:0] mode_q [0:1];
   reg [7:0] dir_q [0:3];
   reg [7:0] drive_q [0:3];
   reg [7:0] latch_q [0:3];
   reg [7:0] cell_q [0:2];
   reg [7:0] mask_q [0:2];
   reg [7:0] icell_q [0:2];
   reg [26:0] sync1_q;
   reg [26:0] sync2_q;
   reg strobe1_q;
   reg strobe2_q;
   reg strobe3_q;
   reg [7:0] rdata_d;
   wire [31:0] pins_w;
   wire [31:0] oe_w;
   wire [31:0] term_w;
   wire [31:0] lgen_w;
   wire [31:0] lgdat_w;
   wire [1:0] port_w;
   wire [3:0] reg_w;
   wire strobe_rise_w;
   wire periph_on_w;
   wire periph_drive_w;
   integer i;

   // Per-bit masks held as vectors, so that one bit is picked by pin index.
   localparam [7:0] PORT_D_PINS = `PORT_D_MASK;
   localparam [7:0] OPEN_DRAIN_BITS = `AB_OPEN_DRAIN_MASK;
   localparam [7:0] SLEW_BITS = `AB_SLEW_MASK;

   assign port_w = host_addr[5:4];
   assign reg_w = host_addr[3:0];
   assign pins_w = {5'h00, sync2_q};
   assign term_w = {5'h00, logic_oe_term};
   assign lgen_w = {5'h00, logic_out_en};
   assign lgdat_w = {5'h00, logic_out_data};

   // Two-stage synchroniser on pins, three-stage delay chain on the address strobe.
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sync1_q <= 27'h0000000;
         sync2_q <= 27'h0000000;
         strobe1_q <= 1'b0;
         strobe2_q <= 1'b0;
         strobe3_q <= 1'b0;
      end
      else
      begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
         strobe1_q <= address_latch_strobe;
         strobe2_q <= strobe1_q;
         strobe3_q <= strobe2_q;
      end
   end

   // Address is latched on the falling edge of the strobe.
   assign strobe_rise_w = strobe3_q & ~strobe2_q;

   // ==========================================================
   // Host writes
   // ==========================================================
   // Configuration and data registers; data latches also clear at reset.
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (i = 0; i < 4; i = i + 1)
         begin
            dir_q[i] <= `CFG_RESET;
            drive_q[i] <= `CFG_RESET;
            latch_q[i] <= 8'h00;
         end
         for (i = 0; i < 3; i = i + 1)
         begin
            cell_q[i] <= 8'h00;
            mask_q[i] <= 8'h00;
         end
         mode_q[0] <= `CFG_RESET;
         mode_q[1] <= `CFG_RESET;
      end
      else
      begin
         if (host_wr)
         begin
            case (reg_w)
               `REG_OUTPUT_LATCH:
               begin
                  latch_q[port_w] <= host_wdata;
               end
               `REG_OUTPUT_CELL:
               begin
                  if (port_w != `PORT_D)
                     cell_q[port_w] <= (cell_q[port_w] & mask_q[port_w]) |
                                       (host_wdata & ~mask_q[port_w]);
               end
               `REG_CELL_MASK:
               begin
                  if (port_w != `PORT_D)
                     mask_q[port_w] <= host_wdata;
               end
               `REG_MODE_CONTROL:
               begin
                  // no mode register on C, D
                  if (port_w == `PORT_A || port_w == `PORT_B)
                     mode_q[port_w[0]] <= host_wdata;
               end
               `REG_DIRECTION:
               begin
                  dir_q[port_w] <= host_wdata;
               end
               `REG_DRIVE_SELECT:
               begin
                  drive_q[port_w] <= host_wdata;
               end
               default:
               begin
               end
            endcase
         end
      end
   end

   // Input cells capture selected address inputs on the strobe.
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (i = 0; i < 3; i = i + 1)
            icell_q[i] <= 8'h00;
      end
      else
      begin
         for (i = 0; i < 3; i = i + 1)
         begin
            if (strobe_rise_w)
               icell_q[i] <= (icell_q[i] & ~addr_input_sel[i*8 +: 8]) |
                             (pins_w[i*8 +: 8] & addr_input_sel[i*8 +: 8]);
         end
      end
   end

   assign input_cell_out = {icell_q[2], icell_q[1], icell_q[0]};
   assign pin_sync_levels = sync2_q;

   // ==========================================================
   // Pin drivers
   // ==========================================================
   // peripheral buffer enable
   assign periph_on_w = memory_map_config_register[`PERIPH_MODE_BIT];
   assign periph_drive_w = (periph_select_first | periph_select_second) & host_data_drive;
   assign host_data_in = sync2_q[7:0];

   genvar g;
   generate
      for (g = 0; g < 27; g = g + 1)
      begin : pin_g
         localparam integer P = g / 8;
         localparam integer B = g % 8;
         wire dir_w;
         wire mode_w;
         wire addr_oe_w;
         wire gen_oe_w;
         wire gen_val_w;
         wire addr_bit_w;
         wire od_w;
         wire drive_val_w;
         wire drive_en_w;
         assign dir_w = (P == 3) ? (dir_q[3][B] & PORT_D_PINS[B]) : dir_q[P][B];
         // mode on A and B only
         assign mode_w = (P < 2) ? mode_q[P % 2][B] : 1'b0;
         // low address on port B when non-multiplexed
         assign addr_bit_w = (P == 1 && host_addr_nonmux) ? host_low_addr[B] :
                             (P == 0) ? host_low_addr[B] : host_high_addr[B];
         assign addr_oe_w = term_w[g] | (dir_w & mode_w);
         // direction or term; via the same OR
         assign gen_oe_w = dir_w | term_w[g];
         // latch or logic array data onto the pin
         assign gen_val_w = lgen_w[g] ? lgdat_w[g] : latch_q[P][B];
         if (P == 0)
         begin : pa_g
            assign drive_en_w = (data_port_mode | periph_on_w) ? periph_drive_w :
                                (mode_w ? addr_oe_w : gen_oe_w);
            assign drive_val_w = (data_port_mode | periph_on_w) ? host_data_out[B] :
                                 (mode_w ? addr_bit_w : gen_val_w);
         end
         else
         begin : pbcd_g
            assign drive_en_w = mode_w ? addr_oe_w : gen_oe_w;
            assign drive_val_w = mode_w ? addr_bit_w : gen_val_w;
         end
         assign od_w = (P == 2) ? drive_q[2][B] :
                       (P < 2) ? (drive_q[P][B] & OPEN_DRAIN_BITS[B]) : 1'b0;
         assign pin_fast_slew[g] = (P == 2) ? 1'b0 :
                                   (P < 2) ? (drive_q[P][B] & SLEW_BITS[B]) :
                                   drive_q[3][B];
         assign pin_out[g] = od_w ? 1'b0 : drive_val_w;
         assign pin_oe_n[g] = ~(drive_en_w & (~od_w | ~drive_val_w));
         assign oe_w[g] = drive_en_w;
      end
   endgenerate
   assign oe_w[31:27] = 5'h00;

   // ==========================================================
   // Host reads
   // ==========================================================
   // Read multiplexer; unmapped reads return zero.
   always @*
   begin
      rdata_d = 8'h00;
      case (reg_w)
         `REG_INPUT_LEVELS:
         begin
            rdata_d = pins_w[port_w*8 +: 8];
         end
         `REG_OUTPUT_LATCH:
         begin
            rdata_d = latch_q[port_w];
         end
         // output cell states, none on port D
         `REG_OUTPUT_CELL:
         begin
            if (port_w != `PORT_D)
               rdata_d = cell_q[port_w];
         end
         // load mask, none on port D
         `REG_CELL_MASK:
         begin
            if (port_w != `PORT_D)
               rdata_d = mask_q[port_w];
         end
         // input cell states, none on port D
         `REG_INPUT_CELL:
         begin
            if (port_w != `PORT_D)
               rdata_d = icell_q[port_w];
         end
         // effective enables, none on port D
         `REG_ENABLE_READBACK:
         begin
            if (port_w != `PORT_D)
               rdata_d = oe_w[port_w*8 +: 8];
         end
         // mode register on ports A and B only
         `REG_MODE_CONTROL:
         begin
            if (port_w == `PORT_A || port_w == `PORT_B)
               rdata_d = mode_q[port_w[0]];
         end
         `REG_DIRECTION:
         begin
            rdata_d = dir_q[port_w];
         end
         `REG_DRIVE_SELECT:
         begin
            rdata_d = drive_q[port_w];
         end
         default:
         begin
            rdata_d = 8'h00;
         end
      endcase
   end

   // Read data registered one cycle after the read strobe.
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         host_rdata <= 8'h00;
      else if (host_rd)
         host_rdata <= rdata_d;
   end

endmodule
`default_nettype wire

// *** tb/io_port_checks_assertions.sv ***
// Port-level assertions for the configurable I/O port block.
`timescale 1ns/1ps
`default_nettype none
module io_port_checks
(
   input wire clock,
   input wire arst_n,
   input wire [5:0] host_addr,
   input wire host_rd,
   input wire [7:0] host_rdata,
   input wire host_data_drive,
   input wire address_latch_strobe,
   input wire data_port_mode,
   input wire [7:0] memory_map_config_register,
   input wire periph_select_first,
   input wire periph_select_second,
   input wire [26:0] logic_oe_term,
   input wire [23:0] addr_input_sel,
   input wire [23:0] input_cell_out,
   input wire [26:0] pin_sync_levels,
   input wire [26:0] pin_in,
   input wire [26:0] pin_oe_n
);
   reg [1:0] up_q;
   default clocking dc @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   // Counts edges since reset, so pin history is never taken from reset.
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         up_q <= 2'h0;
      else if (up_q != 2'h3)
         up_q <= up_q + 2'h1;
   end
   idle_pins_a: assert property ($rose(arst_n) && logic_oe_term == 27'h0
      && !data_port_mode && !memory_map_config_register[7] |-> &pin_oe_n)
      else $error("pin driven after reset");
   term_drive_a: assert property ((logic_oe_term[26:24] == 3'h7) [*2]
      |-> pin_oe_n[26:24] == 3'h0) else $error("term did not enable driver");
   buffer_idle_a: assert property ((memory_map_config_register[7] && !periph_select_first
      && !periph_select_second) [*2] |-> pin_oe_n[7:0] == 8'hff)
      else $error("buffer driven without select");
   buffer_out_a: assert property ((memory_map_config_register[7] && periph_select_first
      && host_data_drive) [*2] |-> pin_oe_n[7:0] == 8'h00) else $error("buffer not driving");
   data_port_a: assert property ((data_port_mode && !memory_map_config_register[7]
      && !host_data_drive && logic_oe_term[7:0] == 8'h00) [*2] |-> pin_oe_n[7:0] == 8'hff)
      else $error("general output on data port");
   pin_sync_a: assert property (up_q == 2'h3 |-> pin_sync_levels == $past(pin_in, 2))
      else $error("pin levels not two cycles behind");
   cell_hold_a: assert property ((!address_latch_strobe && addr_input_sel == 24'hffffff)
      [*8] |-> $stable(input_cell_out)) else $error("cell changed without strobe");
   enable_read_a: assert property (host_rd && host_addr == 6'h15
      |=> host_rdata == ~$past(pin_oe_n[15:8])) else $error("enable readback wrong");
endmodule
`default_nettype wire

// *** tb/pin_world.sv ***
// Far-side pin model: external drivers and pull-ups on every port pin.
`timescale 1ns/1ps
`default_nettype none
module pin_world
(
   input wire logic [26:0] pin_out,
   input wire logic [26:0] pin_oe_n,
   input wire logic [26:0] ext_en,
   input wire logic [26:0] ext_val,
   output logic [26:0] pin_in
);
   // A wire shows the block's driver, else the outside driver, else its pull-up.
   assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val) | (pin_oe_n & ~ext_en);
endmodule
`default_nettype wire

// *** tb/configurable_io_port_block_bench.sv ***
// Self-checking bench for the configurable I/O port block.
`timescale 1ns/1ps
`default_nettype none
module configurable_io_port_block_bench;
   logic clock = 1'b0, arst_n = 1'b0, host_wr = 1'b0, host_rd = 1'b0, host_data_drive = 1'b0;
   logic host_addr_nonmux = 1'b0, address_latch_strobe = 1'b0, data_port_mode = 1'b0;
   logic periph_select_first = 1'b0, periph_select_second = 1'b0;
   logic [5:0] host_addr = 6'h00;
   logic [7:0] host_wdata = 8'h00, host_data_out = 8'h00, host_low_addr = 8'h00, d;
   logic [7:0] host_high_addr = 8'h00, memory_map_config_register = 8'h00;
   logic [7:0] host_rdata, host_data_in;
   logic [26:0] logic_oe_term = 27'h0, logic_out_en = 27'h0, logic_out_data = 27'h0;
   logic [26:0] ext_en = 27'h0, ext_val = 27'h0, pin_in, pin_out, pin_oe_n;
   logic [26:0] pin_fast_slew, pin_sync_levels;
   logic [23:0] addr_input_sel = 24'h0, input_cell_out;
   int err_count = 0, checked = 0;
   // Register rows: address, write data, expected readback.
   logic [21:0] rows [7] = '{{6'h07, 8'ha5, 8'ha5}, {6'h26, 8'hff, 8'h00},
      {6'h13, 8'h0f, 8'h0f}, {6'h12, 8'hff, 8'hf0}, {6'h21, 8'h3c, 8'h3c},
      {6'h18, 8'h0a, 8'h0a}, {6'h32, 8'hff, 8'h00}};
   io_port_block dut_u (.clock, .arst_n, .host_addr, .host_wr, .host_rd, .host_wdata,
      .host_rdata, .host_data_out, .host_data_in, .host_data_drive, .host_addr_nonmux,
      .host_low_addr, .host_high_addr, .address_latch_strobe, .data_port_mode,
      .memory_map_config_register, .periph_select_first, .periph_select_second,
      .logic_oe_term, .logic_out_en, .logic_out_data, .addr_input_sel, .input_cell_out,
      .pin_sync_levels, .pin_in, .pin_out, .pin_oe_n, .pin_fast_slew);
   pin_world far_u (.pin_out, .pin_oe_n, .ext_en, .ext_val, .pin_in);
   // Free-running clock.
   always #5 clock = ~clock;
   // Compares and counts one value.
   task chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", w, exp, seen);
      end
   endtask
   // Host register cycles, changed at the falling edge.
   task wr(input logic [5:0] a, input logic [7:0] v);
      @(negedge clock);
      host_addr = a;
      host_wdata = v;
      host_wr = 1'b1;
      @(negedge clock);
      host_wr = 1'b0;
   endtask
   task rd(input logic [5:0] a, output logic [7:0] v);
      @(negedge clock);
      host_addr = a;
      host_rd = 1'b1;
      @(negedge clock);
      host_rd = 1'b0;
      v = host_rdata;
   endtask
   // Prints the counts and the verdict, then stops.
   task wrap_up();
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Cuts a hung run short.
   initial
   begin
      #300000;
      err_count++;
      wrap_up();
   end
   // Main sequence.
   initial
   begin
      repeat (10) @(negedge clock);
      arst_n = 1'b1;
      foreach (rows[i])
      begin
         wr(rows[i][21:16], rows[i][15:8]);
         rd(rows[i][21:16], d);
         chk("reg", d, rows[i][7:0]);
      end
      chk("slew", pin_fast_slew[15:8], 8'h0a);
      wr(6'h01, 8'h3c);
      chk("a oe", pin_oe_n[7:0], 8'h5a);
      chk("a out", pin_out[7:0] & 8'ha5, 8'h24);
      logic_oe_term = 27'h700000f;
      @(negedge clock);
      chk("term", {pin_oe_n[26:24], pin_oe_n[7:0]}, 11'h050);
      rd(6'h05, d);
      chk("a enable", d, 8'haf);
      rd(6'h15, d);
      chk("b enable", d, 8'h00);
      logic_oe_term = 27'h0;
      host_addr_nonmux = 1'b1;
      host_low_addr = 8'hc3;
      wr(6'h11, 8'h96);
      wr(6'h16, 8'hff);
      chk("mode only", pin_oe_n[15:8], 8'hff);
      wr(6'h17, 8'hff);
      chk("b addr", {pin_oe_n[15:8], pin_out[15:8]}, 16'h00c3);
      wr(6'h16, 8'h00);
      chk("b latch", pin_out[15:8], 8'h96);
      wr(6'h17, 8'h00);
      wr(6'h07, 8'h00);
      ext_en = 27'hffffff;
      ext_val = 27'h810069;
      repeat (3) @(negedge clock);
      rd(6'h00, d);
      chk("a pins", d, 8'h69);
      chk("sync", pin_sync_levels, 27'h7810069);
      addr_input_sel = 24'hffffff;
      address_latch_strobe = 1'b1;
      repeat (2) @(negedge clock);
      address_latch_strobe = 1'b0;
      repeat (8) @(negedge clock);
      chk("c cell", input_cell_out[23:16], 8'h81);
      ext_en = 27'h0;
      wr(6'h28, 8'h01);
      wr(6'h27, 8'h01);
      chk("c low", {pin_oe_n[16], pin_out[16]}, 2'h0);
      wr(6'h21, 8'h01);
      chk("c release", pin_oe_n[16], 1'b1);
      wr(6'h27, 8'h00);
      chk("c slew", pin_fast_slew[23:16], 8'h00);
      // logic term drives the logic data value, then lets the pin go.
      logic_out_en = 27'h20000;
      logic_out_data = 27'h20000;
      logic_oe_term = 27'h20000;
      @(negedge clock);
      chk("c logic", {pin_oe_n[17], pin_out[17]}, 2'h1);
      logic_oe_term = 27'h0;
      @(negedge clock);
      chk("c logic off", pin_oe_n[17], 1'b1);
      memory_map_config_register = 8'h80;
      repeat (2) @(negedge clock);
      chk("buf off", pin_oe_n[7:0], 8'hff);
      periph_select_first = 1'b1;
      host_data_drive = 1'b1;
      host_data_out = 8'h5c;
      repeat (2) @(negedge clock);
      chk("buf out", {pin_oe_n[7:0], pin_out[7:0]}, 16'h005c);
      host_data_drive = 1'b0;
      ext_en = 27'hff;
      ext_val = 27'ha7;
      repeat (3) @(negedge clock);
      chk("buf in", host_data_in, 8'ha7);
      memory_map_config_register = 8'h00;
      periph_select_first = 1'b0;
      data_port_mode = 1'b1;
      wr(6'h07, 8'hff);
      chk("data port", pin_oe_n[7:0], 8'hff);
      wr(6'h37, 8'hff);
      wr(6'h31, 8'hfd);
      chk("d out", {pin_oe_n[26:24], pin_out[26:24]}, 6'h05);
      // reset in mid-run clears the configuration and idles the pins.
      data_port_mode = 1'b0;
      arst_n = 1'b0;
      repeat (2) @(negedge clock);
      arst_n = 1'b1;
      chk("idle", pin_oe_n, 27'h7ffffff);
      for (int i = 0; i < 12; i++)
      begin
         rd({2'(i / 3), 4'(6 + i % 3)}, d);
         chk("config", d, 8'h00);
      end
      wrap_up();
   end
endmodule
bind io_port_block io_port_checks chk_u (.clock, .arst_n, .host_addr, .host_rd, .host_rdata,
   .host_data_drive, .address_latch_strobe, .data_port_mode, .memory_map_config_register,
   .periph_select_first, .periph_select_second, .logic_oe_term, .addr_input_sel,
   .input_cell_out, .pin_sync_levels, .pin_in, .pin_oe_n);
`default_nettype wire
